// ===== testbench/tb.sv
// tb.sv: self-checking bench for the training framer
// assumes tif_consts.vh on the include path and the checker bound in
`timescale 1ns/10ps
`include "tif_consts.vh"

module tb;
  reg sys_clk_in, nrst_in, scr_bit, rcvr_ok, awvalid, wvalid, bready, arvalid, rready;
  reg [4:0] awaddr, araddr;
  reg [31:0] wdata, rnd;
  reg [3:0] wstrb;
  wire awready, wready, bvalid, arready, rvalid, tbit, fstart, rx_valid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [95:0] rx_msg;
  integer seed, mismatches, check_count, rx_count, k;
  reg [1:0] exp_b[$];
  reg [33:0] exp_r[$];
  reg [95:0] exp_m[$];

  tif_framer dut (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .scr_bit_in(scr_bit), .loc_rcvr_ok_in(rcvr_ok),
    .s_axi_awaddr_in(awaddr), .s_axi_awprot_in(3'h0), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
    .s_axi_arprot_in(3'h0), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .training_bit_out(tbit),
    .frame_start_out(fstart));
  tif_partner u_far (.clk_in(sys_clk_in), .nrst_in(nrst_in), .scr_in(scr_bit), .line_in(tbit),
    .frame_start_in(fstart), .msg_out(rx_msg), .msg_valid_out(rx_valid));

  initial begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end

  always @(posedge sys_clk_in) begin
    rnd = $random(seed);
    scr_bit <= rnd[0];
  end

  // ****************************************
  // expectations and comparisons
  // ****************************************
  function [95:0] mk_msg(input [23:0] cnt, input [7:0] m, input [23:0] pay);
    reg [55:0] d;
    reg [15:0] c;
    integer i;
    begin
      d = {pay, m, cnt};
      c = 16'h0000;
      for (i = 0; i < 56; i = i + 1) c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? `TIF_CRC_POLY : 16'h0000);
      for (i = 0; i < 16; i = i + 1) mk_msg[80 + i] = c[15 - i];
      mk_msg[79:0] = {d, `TIF_DELIM};
    end
  endfunction

  task cmp_resp(input [1:0] e, input [1:0] g);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("ERROR bresp expected %h seen %h", e, g);
      end
    end
  endtask

  task cmp_read(input [33:0] e, input [33:0] g);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("ERROR read expected %h seen %h", e, g);
      end
    end
  endtask

  task cmp_msg(input [95:0] e, input [95:0] g);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("ERROR side_message expected %h seen %h", e, g);
      end
    end
  endtask

  always @(posedge sys_clk_in) begin
    if (bvalid === 1'b1 && bready) cmp_resp(exp_b.pop_front(), bresp);
    if (rvalid === 1'b1 && rready) cmp_read(exp_r.pop_front(), {rresp, rdata});
    if (rx_valid === 1'b1) begin
      rx_count = rx_count + 1;
      cmp_msg(exp_m.pop_front(), rx_msg);
    end
  end

  // ****************************************
  // bus master; a slow call makes the answer wait
  // ****************************************
  task axi_wr(input [4:0] a, input [31:0] d, input [1:0] r, input slow);
    reg done;
    begin
      @(posedge sys_clk_in);
      exp_b.push_back(r);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= !slow;
      done = 1'b0;
      while (!done) begin
        @(posedge sys_clk_in);
        if (awready === 1'b1 && awvalid) awvalid <= 1'b0;
        if (wready === 1'b1 && wvalid) wvalid <= 1'b0;
        if (bvalid === 1'b1 && bready) begin
          bready <= 1'b0;
          done = 1'b1;
        end else if (bvalid === 1'b1) bready <= 1'b1;
      end
    end
  endtask

  task axi_rd(input [4:0] a, input [31:0] d, input [1:0] r, input slow);
    reg done;
    begin
      @(posedge sys_clk_in);
      exp_r.push_back({r, d});
      araddr <= a;
      arvalid <= 1'b1;
      rready <= !slow;
      done = 1'b0;
      while (!done) begin
        @(posedge sys_clk_in);
        if (arready === 1'b1 && arvalid) arvalid <= 1'b0;
        if (rvalid === 1'b1 && rready) begin
          rready <= 1'b0;
          done = 1'b1;
        end else if (rvalid === 1'b1) rready <= 1'b1;
      end
    end
  endtask

  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
        $display("verification passed");
      end else begin
        $display("verification failed");
      end
      $finish;
    end
  endtask

  initial begin
    repeat (60000) @(posedge sys_clk_in);
    mismatches = mismatches + 1;
    tally_and_finish;
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    seed = 31563;
    mismatches = 0;
    check_count = 0;
    rx_count = 0;
    {nrst_in, rcvr_ok, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
    {awaddr, araddr, wdata} = 42'h0;
    wstrb = 4'hf;
    repeat (6) @(posedge sys_clk_in);
    nrst_in <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
    axi_rd(`TIF_OFS_CTRL, 32'h0000_0000, `TIF_RESP_OKAY, 1'b0);
    axi_rd(`TIF_OFS_CAP, 32'h0000_0000, `TIF_RESP_OKAY, 1'b1);
    axi_rd(`TIF_OFS_SWITCH, 32'h0000_0000, `TIF_RESP_OKAY, 1'b0);
    axi_wr(`TIF_OFS_CAP, 32'hffff_ffff, `TIF_RESP_OKAY, 1'b1);
    axi_rd(`TIF_OFS_CAP, 32'h001f_8000, `TIF_RESP_OKAY, 1'b0);
    axi_wr(`TIF_OFS_SWITCH, 32'hab12_3450, `TIF_RESP_OKAY, 1'b0);
    axi_rd(`TIF_OFS_SWITCH, 32'h0012_3450, `TIF_RESP_OKAY, 1'b0);
    // only byte lane 1 may change
    wstrb <= 4'h2;
    axi_wr(`TIF_OFS_SWITCH, 32'hffff_ffff, `TIF_RESP_OKAY, 1'b0);
    wstrb <= 4'hf;
    axi_rd(`TIF_OFS_SWITCH, 32'h0012_ff50, `TIF_RESP_OKAY, 1'b0);
    axi_wr(5'h14, 32'h0000_0001, `TIF_RESP_SLVERR, 1'b0);
    axi_rd(5'h14, 32'h0000_0000, `TIF_RESP_SLVERR, 1'b0);
    axi_wr(`TIF_OFS_STATUS, 32'hffff_ffff, `TIF_RESP_OKAY, 1'b0);
    axi_rd(`TIF_OFS_CTRL, 32'h0000_0000, `TIF_RESP_OKAY, 1'b0);
    // row and payload stay put: content must repeat many times first
    for (k = 0; k < 5; k = k + 1) exp_m.push_back(mk_msg(24'h00_000f + 24'(16 * k), 8'h00, 24'h1f_8000));
    axi_wr(`TIF_OFS_CTRL, 32'h0000_0001, `TIF_RESP_OKAY, 1'b0);
    while (rx_count < 2) @(posedge sys_clk_in);
    rcvr_ok <= 1'b1;
    axi_wr(`TIF_OFS_CTRL, 32'h0000_000f, `TIF_RESP_OKAY, 1'b0);
    axi_rd(`TIF_OFS_CTRL, 32'h0000_000f, `TIF_RESP_OKAY, 1'b0);
    while (rx_count < 5) @(posedge sys_clk_in);
    // row held at 0 by the repeat rule, receiver ok seen, still in sub-frame 15
    axi_rd(`TIF_OFS_STATUS, 32'h0000_01f0, `TIF_RESP_OKAY, 1'b0);
    @(posedge sys_clk_in);
    tally_and_finish;
  end
endmodule // tb

// ===== testbench/tif_framer_chk.sv
// tif_framer_chk.sv: port-level checks for the training framer
// assumes tif_consts.vh on the include path; bound onto tif_framer below
`timescale 1ns/10ps
`include "tif_consts.vh"

module tif_framer_chk (
  input wire sys_clk_in,
  input wire nrst_in,
  input wire scr_bit_in,
  input wire [1:0] s_axi_bresp_out,
  input wire s_axi_bvalid_out,
  input wire s_axi_bready_in,
  input wire s_axi_arvalid_in,
  input wire s_axi_arready_out,
  input wire [31:0] s_axi_rdata_out,
  input wire s_axi_rvalid_out,
  input wire s_axi_rready_in,
  input wire training_bit_out,
  input wire frame_start_out
);
  localparam [23:0] DELIM = `TIF_DELIM;
  reg [12:0] idx_reg;
  reg seen_reg;
  wire [12:0] idx = frame_start_out ? 13'h0000 : idx_reg;
  wire live = seen_reg | frame_start_out;
  wire first = (idx % `TIF_SUB_LEN) == 13'h0000;

  // ****************************************
  // bit position, anchored on the frame pulse
  // ****************************************
  // saturates so an idle stream never wraps into a false frame
  always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      idx_reg <= 13'h0000;
      seen_reg <= 1'b0;
    end else begin
      seen_reg <= live;
      if (frame_start_out) begin
        idx_reg <= 13'h0001;
      end else if (idx_reg != 13'h1fff) begin
        idx_reg <= idx_reg + 13'h0001;
      end
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);

  chk_frame_len: assert property (frame_start_out && seen_reg |-> idx_reg == 13'h1c20)
    else $error("frame pulse spacing wrong");
  chk_frame_pulse: assert property (frame_start_out |=> !frame_start_out)
    else $error("frame pulse longer than one cycle");
  chk_sub_invert: assert property (live && idx < `TIF_MSG_FIRST && first |-> training_bit_out != $past(scr_bit_in))
    else $error("sub-frame first bit not inverted");
  chk_plain_pass: assert property (live && ((idx < `TIF_MSG_FIRST && !first) || (idx > `TIF_MSG_LAST && idx < 13'h1c20))
    |-> training_bit_out == $past(scr_bit_in))
    else $error("plain bit altered");
  chk_delim_bits: assert property (live && idx >= `TIF_MSG_FIRST && idx <= 13'h1a75
    |-> training_bit_out == ($past(scr_bit_in) ^ DELIM[idx - `TIF_MSG_FIRST]))
    else $error("delimiter bit wrong");
  chk_b_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("write response dropped early");
  chk_b_release: assert property (s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out)
    else $error("write response not released");
  chk_r_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read data dropped early");
  chk_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> !s_axi_arready_out && s_axi_rvalid_out)
    else $error("read answer late");
endmodule // tif_framer_chk

bind tif_framer tif_framer_chk u_chk (
  .sys_clk_in(sys_clk_in),
  .nrst_in(nrst_in),
  .scr_bit_in(scr_bit_in),
  .s_axi_bresp_out(s_axi_bresp_out),
  .s_axi_bvalid_out(s_axi_bvalid_out),
  .s_axi_bready_in(s_axi_bready_in),
  .s_axi_arvalid_in(s_axi_arvalid_in),
  .s_axi_arready_out(s_axi_arready_out),
  .s_axi_rdata_out(s_axi_rdata_out),
  .s_axi_rvalid_out(s_axi_rvalid_out),
  .s_axi_rready_in(s_axi_rready_in),
  .training_bit_out(training_bit_out),
  .frame_start_out(frame_start_out)
);

// ===== testbench/tif_partner.sv
// tif_partner.sv: far-end receiver that pulls the side message off the line
// assumes it shares the scrambler reference bit, as a locked descrambler would
`timescale 1ns/10ps
`include "tif_consts.vh"

module tif_partner (
  input wire clk_in,
  input wire nrst_in,
  input wire scr_in,
  input wire line_in,
  input wire frame_start_in,
  output reg [95:0] msg_out,
  output reg msg_valid_out
);
  reg [12:0] pos_reg;
  reg scr_reg;
  reg seen_reg;
  wire [12:0] p = frame_start_in ? 13'h0000 : pos_reg;
  wire [3:0] row_hi = msg_out[55:52];
  // octet 7 bits 3:0 are reserved and not looked at
  wire row_ok = (row_hi == 4'h0) || (row_hi == 4'h1) || (row_hi == 4'h3) || (row_hi == 4'h7);

  // ****************************************
  // capture and report
  // ****************************************
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pos_reg <= 13'h0000;
      scr_reg <= 1'b0;
      seen_reg <= 1'b0;
      msg_out <= 96'h0;
      msg_valid_out <= 1'b0;
    end else begin
      scr_reg <= scr_in;
      seen_reg <= seen_reg | frame_start_in;
      pos_reg <= p + 13'h0001;
      msg_valid_out <= 1'b0;
      if (p >= `TIF_MSG_FIRST && p <= `TIF_MSG_LAST) begin
        msg_out[p - `TIF_MSG_FIRST] <= line_in ^ scr_reg;
      end
      // malformed messages are dropped; decoding every one is not required
      if (seen_reg && p == 13'h1abe && msg_out[23:0] == `TIF_DELIM && row_ok) begin
        msg_valid_out <= 1'b1;
      end
    end
  end
endmodule // tif_partner

// ===== verilog/tif_consts.vh
// tif_consts.vh: offsets, field positions, reset values and counts for the training framer
// assumes inclusion by bare name; shared by the framer and its bench
`ifndef TIF_CONSTS_VH
`define TIF_CONSTS_VH

// ****************************************
// frame geometry
// ****************************************
`define TIF_SUB_LEN 9'h01c2
`define TIF_SUB_LAST 9'h01c1
`define TIF_SUBS_LAST 4'hf
`define TIF_FRAME_LAST 13'h1c1f
`define TIF_MSG_FIRST 13'h1a5e
`define TIF_MSG_LAST 13'h1abd
`define TIF_MSG_BUILD 13'h1a5d
`define TIF_REPEAT_MIN 9'h0100

// ****************************************
// side message contents
// ****************************************
`define TIF_DELIM 24'h00_a7bb
`define TIF_CRC_POLY 16'h8005
`define TIF_CAP_MASK 24'h1f_8000
`define TIF_PHASE_TRAIN 2'h0
`define TIF_PHASE_COUNT 2'h1

// ****************************************
// register offsets and fields
// ****************************************
`define TIF_OFS_CTRL 5'h00
`define TIF_OFS_CAP 5'h04
`define TIF_OFS_SWITCH 5'h08
`define TIF_OFS_STATUS 5'h0c
`define TIF_OFS_COUNT 5'h10
`define TIF_CTRL_EN 0
`define TIF_CTRL_FOLLOWER 1
`define TIF_CTRL_COUNTDOWN 2
`define TIF_CTRL_FLAG4 3
`define TIF_CTRL_RESET 4'h0
`define TIF_CAP_RESET 24'h00_0000
`define TIF_SWITCH_RESET 24'h00_0000
`define TIF_RESP_OKAY 2'h0
`define TIF_RESP_SLVERR 2'h2

`endif

// ===== verilog/tif_framer.v
// tif_framer.v: training bit framer with side message insertion and an AXI4-Lite register slave
// assumes scr_bit_in is bit 0 of a scrambler on sys_clk_in, one bit per clock, and a 32-bit AXI4-Lite master
//
// How it works
// - sub-frames of 450 bits from bit zero
// - sixteen sub-frames form one block
// - invert first bit of sub-frames 0 to 14
// - bits 6750..6845 carry side message bits
// - otherwise scrambler bit passes unchanged
// - side message only while training enabled
// - each content repeated 256 times before change
// - receive decoding rate is the partner's concern
// - delimiter, count, message, payload, check layout
// - reserved side message bits sent as zero
// - octet 1 first, each octet lsb first
// - delimiter octets bb, a7, 00
// - octets 4..6 carry running sub-frame count
// - first sub-frame is zero, first count 15
// - leader octet 7: phase, rx ok, tx enable
// - follower bit 4 carries clock lock good
// - phase 00 training, 01 countdown
// - only valid message rows are sent
// - first message row is the first row; the code sends the requested row, up to row 3
// - message row never moves back
// - leader rows in fixed order
// - follower rows in fixed order
// - receiver ok bit follows receiver status; the code keeps it at 1 once row 2 is sent, since the row never moves back
// - countdown payload is switch sub-frame count
//
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/10ps
`include "tif_consts.vh"

module tif_framer (
  input wire sys_clk_in,
  input wire nrst_in,
  input wire scr_bit_in,
  input wire loc_rcvr_ok_in,
  input wire [4:0] s_axi_awaddr_in,
  input wire [2:0] s_axi_awprot_in,
  input wire s_axi_awvalid_in,
  output wire s_axi_awready_out,
  input wire [31:0] s_axi_wdata_in,
  input wire [3:0] s_axi_wstrb_in,
  input wire s_axi_wvalid_in,
  output wire s_axi_wready_out,
  output wire [1:0] s_axi_bresp_out,
  output wire s_axi_bvalid_out,
  input wire s_axi_bready_in,
  input wire [4:0] s_axi_araddr_in,
  input wire [2:0] s_axi_arprot_in,
  input wire s_axi_arvalid_in,
  output wire s_axi_arready_out,
  output wire [31:0] s_axi_rdata_out,
  output wire [1:0] s_axi_rresp_out,
  output wire s_axi_rvalid_out,
  input wire s_axi_rready_in,
  output wire training_bit_out,
  output wire frame_start_out
);

  // ****************************************
  // functions
  // ****************************************
  function [31:0] tif_merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0] strb;
    integer i;
    begin
      tif_merge = old_val;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          tif_merge[i*8 +: 8] = new_val[i*8 +: 8];
        end
      end
    end
  endfunction

  // serial check generator, octet 4 lsb first through octet 10
  function [15:0] tif_crc;
    input [55:0] data;
    integer i;
    reg fb;
    begin
      tif_crc = 16'h0000;
      fb = 1'b0;
      for (i = 0; i < 56; i = i + 1) begin
        fb = tif_crc[15] ^ data[i];
        tif_crc = {tif_crc[14:0], 1'b0} ^ (fb ? `TIF_CRC_POLY : 16'h0000);
      end
    end
  endfunction

  // ****************************************
  // reset release and pin synchroniser
  // ****************************************
  reg rst_meta_reg, rst_n_reg;
  wire rst_n;
  reg [2:0] rcvr_sync_reg;
  reg rcvr_ok_reg;

  always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end
  assign rst_n = rst_n_reg;

  // change accepted only when the last two stages agree, filtering one-cycle glitches
  always @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rcvr_sync_reg <= 3'h0;
      rcvr_ok_reg <= 1'b0;
    end else begin
      rcvr_sync_reg <= {rcvr_sync_reg[1:0], loc_rcvr_ok_in};
      if (rcvr_sync_reg[1] == rcvr_sync_reg[2]) begin
        rcvr_ok_reg <= rcvr_sync_reg[2];
      end
    end
  end

  // ****************************************
  // registers
  // ****************************************
  reg [3:0] ctrl_reg, wstrb_reg;
  reg [23:0] cap_reg, switch_reg;
  reg awready_reg, wready_reg, aw_held_reg, w_held_reg, bvalid_reg, arready_reg, rvalid_reg;
  reg [4:0] awaddr_reg;
  reg [31:0] wdata_reg, rdata_reg;
  reg [1:0] bresp_reg, rresp_reg;

  // framing state
  reg [12:0] bit_idx_reg;
  reg [8:0] sub_pos_reg, repeat_reg;
  reg [3:0] sub_idx_reg;
  reg [23:0] subframe_counter_reg, payload_reg;
  reg [95:0] side_message_reg;
  reg [1:0] row_reg;
  reg training_bit_reg, frame_start_reg;

  wire enable;
  reg [31:0] status_word, read_word;
  reg read_ok;
  assign enable = ctrl_reg[`TIF_CTRL_EN];

  // ****************************************
  // axi4-lite write channel
  // ****************************************
  wire write_go;
  wire [31:0] ctrl_merged, cap_merged, switch_merged;

  assign write_go = aw_held_reg && w_held_reg && !bvalid_reg;
  assign ctrl_merged = tif_merge({28'h000_0000, ctrl_reg}, wdata_reg, wstrb_reg);
  assign cap_merged = tif_merge({8'h00, cap_reg}, wdata_reg, wstrb_reg);
  assign switch_merged = tif_merge({8'h00, switch_reg}, wdata_reg, wstrb_reg);

  always @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 5'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `TIF_RESP_OKAY;
      ctrl_reg <= `TIF_CTRL_RESET;
      cap_reg <= `TIF_CAP_RESET;
      switch_reg <= `TIF_SWITCH_RESET;
    end else begin
      if (s_axi_awvalid_in && awready_reg) begin
        awaddr_reg <= s_axi_awaddr_in;
        aw_held_reg <= 1'b1;
        awready_reg <= 1'b0;
      end else if (!aw_held_reg && !bvalid_reg) begin
        awready_reg <= 1'b1;
      end
      if (s_axi_wvalid_in && wready_reg) begin
        wdata_reg <= s_axi_wdata_in;
        wstrb_reg <= s_axi_wstrb_in;
        w_held_reg <= 1'b1;
        wready_reg <= 1'b0;
      end else if (!w_held_reg && !bvalid_reg) begin
        wready_reg <= 1'b1;
      end
      if (write_go) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= `TIF_RESP_OKAY;
        if (awaddr_reg == `TIF_OFS_CTRL) begin
          ctrl_reg <= ctrl_merged[3:0];
        end else if (awaddr_reg == `TIF_OFS_CAP) begin
          cap_reg <= cap_merged[23:0] & `TIF_CAP_MASK;
        end else if (awaddr_reg == `TIF_OFS_SWITCH) begin
          switch_reg <= switch_merged[23:0];
        end else if (awaddr_reg == `TIF_OFS_STATUS || awaddr_reg == `TIF_OFS_COUNT) begin
          bresp_reg <= `TIF_RESP_OKAY;
        end else begin
          bresp_reg <= `TIF_RESP_SLVERR;
        end
      end else if (bvalid_reg && s_axi_bready_in) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // ****************************************
  // axi4-lite read channel
  // ****************************************
  // the message actually on the line is readable, so software can pace its own decisions
  always @* begin
    status_word = {8'h00, side_message_reg[55:48], 6'h00, repeat_reg >= `TIF_REPEAT_MIN,
                   rcvr_ok_reg, sub_idx_reg, 2'h0, row_reg};
    read_ok = 1'b1;
    if (s_axi_araddr_in == `TIF_OFS_CTRL) begin
      read_word = {28'h000_0000, ctrl_reg};
    end else if (s_axi_araddr_in == `TIF_OFS_CAP) begin
      read_word = {8'h00, cap_reg};
    end else if (s_axi_araddr_in == `TIF_OFS_SWITCH) begin
      read_word = {8'h00, switch_reg};
    end else if (s_axi_araddr_in == `TIF_OFS_STATUS) begin
      read_word = status_word;
    end else if (s_axi_araddr_in == `TIF_OFS_COUNT) begin
      read_word = {8'h00, subframe_counter_reg};
    end else begin
      read_word = 32'h0000_0000;
      read_ok = 1'b0;
    end
  end

  always @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `TIF_RESP_OKAY;
    end else begin
      if (s_axi_arvalid_in && arready_reg) begin
        arready_reg <= 1'b0;
        rvalid_reg <= 1'b1;
        rdata_reg <= read_word;
        rresp_reg <= read_ok ? `TIF_RESP_OKAY : `TIF_RESP_SLVERR;
      end else if (rvalid_reg && s_axi_rready_in) begin
        rvalid_reg <= 1'b0;
      end else if (!rvalid_reg) begin
        arready_reg <= 1'b1;
      end
    end
  end

  // ****************************************
  // message row selection
  // ****************************************
  // rows: 0 = 00,0,0 1 = 00,0,1 2 = 00,1,1 3 = 01,1,1 for both roles
  // a combination outside the table falls to the highest valid row it satisfies
  reg [1:0] req_row, next_row;
  reg [7:0] octet7;
  reg [23:0] next_payload;
  wire flag4;

  assign flag4 = ctrl_reg[`TIF_CTRL_FLAG4]; // tx enable as leader, clock lock good as follower

  always @* begin
    if (rcvr_ok_reg && flag4 && ctrl_reg[`TIF_CTRL_COUNTDOWN]) begin
      req_row = 2'h3;
    end else if (rcvr_ok_reg && flag4) begin
      req_row = 2'h2;
    end else if (flag4) begin
      req_row = 2'h1;
    end else begin
      req_row = 2'h0;
    end
    next_row = (req_row > row_reg) ? req_row : row_reg;
    next_payload = (next_row == 2'h3) ? switch_reg : cap_reg;
  end

  // ****************************************
  // side message assembly
  // ****************************************
  // content is committed only after the current one has gone out 256 times
  wire may_change;
  wire [1:0] msg_row;
  wire [23:0] msg_payload, msg_count;
  wire [55:0] crc_data;
  wire [15:0] crc_val;
  reg [15:0] crc_rev;
  integer k;

  assign may_change = (repeat_reg >= `TIF_REPEAT_MIN) || (repeat_reg == 9'h000);
  assign msg_row = may_change ? next_row : row_reg;
  assign msg_payload = may_change ? next_payload : payload_reg;
  assign msg_count = subframe_counter_reg + 24'h00_0001; // sub-frame 15 of the frame

  always @* begin
    case (msg_row)
      2'h0: octet7 = {`TIF_PHASE_TRAIN, 1'b0, 1'b0, 4'h0};
      2'h1: octet7 = {`TIF_PHASE_TRAIN, 1'b0, 1'b1, 4'h0};
      2'h2: octet7 = {`TIF_PHASE_TRAIN, 1'b1, 1'b1, 4'h0};
      default: octet7 = {`TIF_PHASE_COUNT, 1'b1, 1'b1, 4'h0};
    endcase
  end

  assign crc_data = {msg_payload, octet7, msg_count};
  assign crc_val = tif_crc(crc_data);

  // s15 goes out first, so it sits at the lowest check position
  always @* begin
    crc_rev = 16'h0000;
    for (k = 0; k < 16; k = k + 1) begin
      crc_rev[k] = crc_val[15 - k];
    end
  end

  // ****************************************
  // bit framing
  // ****************************************
  wire in_msg, sub_first, frame_wrap;

  assign in_msg = (bit_idx_reg >= `TIF_MSG_FIRST) && (bit_idx_reg <= `TIF_MSG_LAST);
  assign sub_first = (sub_pos_reg == 9'h000);
  assign frame_wrap = (bit_idx_reg == `TIF_FRAME_LAST);

  always @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      bit_idx_reg <= 13'h0000;
      sub_pos_reg <= 9'h000;
      sub_idx_reg <= 4'h0;
      subframe_counter_reg <= 24'h00_0000;
      side_message_reg <= {72'h00_0000_0000_0000_0000, `TIF_DELIM};
      row_reg <= 2'h0;
      payload_reg <= `TIF_CAP_RESET;
      repeat_reg <= 9'h000;
      training_bit_reg <= 1'b0;
      frame_start_reg <= 1'b0;
    end else if (!enable) begin
      // outside training the line carries the plain scrambler and the framer restarts
      bit_idx_reg <= 13'h0000;
      sub_pos_reg <= 9'h000;
      sub_idx_reg <= 4'h0;
      subframe_counter_reg <= 24'h00_0000;
      row_reg <= 2'h0;
      repeat_reg <= 9'h000;
      training_bit_reg <= scr_bit_in;
      frame_start_reg <= 1'b0;
    end else begin
      bit_idx_reg <= frame_wrap ? 13'h0000 : bit_idx_reg + 13'h0001;
      if (sub_pos_reg == `TIF_SUB_LAST) begin
        sub_pos_reg <= 9'h000;
        sub_idx_reg <= frame_wrap ? 4'h0 : sub_idx_reg + 4'h1;
        subframe_counter_reg <= subframe_counter_reg + 24'h00_0001;
      end else begin
        sub_pos_reg <= sub_pos_reg + 9'h001;
      end
      if (bit_idx_reg == `TIF_MSG_BUILD) begin
        side_message_reg <= {crc_rev, msg_payload, octet7, msg_count, `TIF_DELIM};
        row_reg <= msg_row;
        payload_reg <= msg_payload;
        if (may_change && (msg_row != row_reg || msg_payload != payload_reg || repeat_reg == 9'h000)) begin
          repeat_reg <= 9'h001;
        end else if (repeat_reg < `TIF_REPEAT_MIN) begin
          repeat_reg <= repeat_reg + 9'h001;
        end
      end
      if (in_msg) begin
        training_bit_reg <= scr_bit_in ^ side_message_reg[sub_pos_reg[6:0]];
      end else if (sub_first) begin
        training_bit_reg <= ~scr_bit_in;
      end else begin
        training_bit_reg <= scr_bit_in;
      end
      frame_start_reg <= (bit_idx_reg == 13'h0000);
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign s_axi_awready_out = awready_reg;
  assign s_axi_wready_out = wready_reg;
  assign s_axi_bresp_out = bresp_reg;
  assign s_axi_bvalid_out = bvalid_reg;
  assign s_axi_arready_out = arready_reg;
  assign s_axi_rdata_out = rdata_reg;
  assign s_axi_rresp_out = rresp_reg;
  assign s_axi_rvalid_out = rvalid_reg;
  assign training_bit_out = training_bit_reg;
  assign frame_start_out = frame_start_reg;

endmodule // tif_framer
